// ### logic/vfd_host_pkg.sv
package vfd_host_pkg;

	// ----------------------------------------------------------------
	// interface mode jumper codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_ENABLE_STROBE = 2'h0;
	localparam logic [1:0] MODE_SEPARATE_STROBE = 2'h1;
	localparam logic [1:0] MODE_SERIAL = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWRUP_RESET_TIME_US = 100;
	localparam int PWRUP_RESET_CYCLES = (PWRUP_RESET_TIME_US * 1000) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// serial frame
	// ----------------------------------------------------------------
	localparam logic [4:0] SER_FRAME_BITS = 5'h10;
	localparam logic [4:0] SER_START_BITS = 5'h08;
	localparam logic [3:0] SER_PAYLOAD_BITS = 4'h8;
	localparam logic [4:0] SER_START_ONES = 5'h1F;
	localparam int SER_RW_POS = 2;
	localparam int SER_RS_POS = 1;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RX_VALUE = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TX_INSTR = 8'h08;
	localparam logic [7:0] REG_TX_DATA = 8'h0C;

	// status fields and the register select bit of the rx value
	localparam int ST_RX_VALID = 0;
	localparam int ST_RD_DONE = 1;
	localparam int ST_MODE_LO = 2;
	localparam int ST_WIDE = 4;
	localparam int ST_RESET = 5;
	localparam int ST_HI_NEXT = 6;
	localparam int RX_RS_POS = 8;

	// reset values
	localparam logic [7:0] TX_INSTR_RESET = 8'h00;
	localparam logic [7:0] TX_DATA_RESET = 8'h00;

endpackage : vfd_host_pkg

// ### logic/vfd_host_interface.sv
`timescale 1ns/1ps
`default_nettype none

module vfd_host_interface #(
	parameter int POR_CYCLES = vfd_host_pkg::PWRUP_RESET_CYCLES
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// jumpers
	input  wire logic [1:0]  MODE_SEL,
	input  wire logic        WIDE_SEL,
	input  wire logic        EXT_RESET_SEL,
	input  wire logic        EXT_RESET_N,
	// parallel host pins
	input  wire logic        ENABLE_STROBE,
	input  wire logic        READ_WRITE,
	input  wire logic        WRITE_STROBE_N,
	input  wire logic        READ_STROBE_N,
	input  wire logic        REGISTER_SELECT,
	input  wire logic [7:0]  DATA_BUS_LINES_IN,
	output logic      [7:0]  DATA_BUS_LINES_OUT,
	output logic             DATA_BUS_LINES_OE,
	// serial host pins
	input  wire logic        FRAME_SELECT_N,
	input  wire logic        SHIFT_CLK,
	input  wire logic        SERIAL_IN,
	output logic             SERIAL_OUT,
	output logic             SERIAL_OE,
	// to display core
	output logic             CORE_RESET
);

	localparam int CW = $clog2(POR_CYCLES + 1);

	if (POR_CYCLES < 1) begin : g_chk
		$error("POR_CYCLES must be at least one");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic       wide;
		logic       ext_sel;
		logic       ext_n;
		logic       en;
		logic       rw;
		logic       wr_n;
		logic       rd_n;
		logic       rs;
		logic [7:0] data;
		logic       fs_n;
		logic       sck;
		logic       si;
	} pins_s;

	typedef struct packed {
		pins_s       p1;
		pins_s       p2;
		pins_s       p3;
		logic [CW-1:0] por_cnt;
		logic        rst_act;
		logic        hi_next;
		logic [3:0]  hold_nib;
		logic [7:0]  rx_data;
		logic        rx_rs;
		logic        rx_valid;
		logic        rd_done;
		logic [7:0]  tx_instr;
		logic [7:0]  tx_data;
		logic        s_act;
		logic        s_bad;
		logic        s_rw;
		logic        s_rs;
		logic [4:0]  bcnt;
		logic [3:0]  ocnt;
		logic [7:0]  sh;
		logic [7:0]  out_sh;
		logic [7:0]  bus_out;
		logic        bus_oe;
		logic        ser_out;
		logic        ser_oe;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} st_s;

	st_s  st_r;
	st_s  st_nxt;
	logic rst_m_r;
	logic rst_n_r;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	// ----------------------------------------------------------------
	// decoded events
	// ----------------------------------------------------------------
	pins_s pin_now;
	logic  par;
	logic  es;
	logic  ss;
	logic  ser;
	logic  wr_ev;
	logic  rd_start;
	logic  rd_end;
	logic  sck_rise;
	logic  sck_fall;
	logic  fs_fall;
	logic  fs_rise;
	logic  ext_req;
	logic  apb_wr;
	logic  start_ok;
	logic [7:0] start_byte;
	logic [7:0] rd_val;

	assign pin_now = '{MODE_SEL, WIDE_SEL, EXT_RESET_SEL, EXT_RESET_N, ENABLE_STROBE,
		READ_WRITE, WRITE_STROBE_N, READ_STROBE_N, REGISTER_SELECT, DATA_BUS_LINES_IN,
		FRAME_SELECT_N, SHIFT_CLK, SERIAL_IN};

	assign es = st_r.p2.mode == vfd_host_pkg::MODE_ENABLE_STROBE;
	assign ss = st_r.p2.mode == vfd_host_pkg::MODE_SEPARATE_STROBE;
	assign par = es | ss;
	assign ser = !par;
	assign wr_ev = !st_r.rst_act & ((es & st_r.p3.en & !st_r.p2.en & !st_r.p2.rw)
		| (ss & !st_r.p3.wr_n & st_r.p2.wr_n));
	assign rd_start = !st_r.rst_act & ((es & !st_r.p3.en & st_r.p2.en & st_r.p2.rw)
		| (ss & st_r.p3.rd_n & !st_r.p2.rd_n));
	assign rd_end = st_r.bus_oe & ((es & st_r.p3.en & !st_r.p2.en)
		| (ss & !st_r.p3.rd_n & st_r.p2.rd_n));
	assign sck_rise = ser & !st_r.p3.sck & st_r.p2.sck;
	assign sck_fall = ser & st_r.p3.sck & !st_r.p2.sck;
	assign fs_fall = ser & !st_r.rst_act & st_r.p3.fs_n & !st_r.p2.fs_n;
	assign fs_rise = ser & !st_r.p3.fs_n & st_r.p2.fs_n;
	assign ext_req = par & st_r.p2.ext_sel & !st_r.p2.ext_n;
	assign apb_wr = PSEL & PENABLE & PWRITE & st_r.pready;
	assign start_byte = {st_r.sh[6:0], st_r.p2.si};
	assign start_ok = start_byte[7:3] == vfd_host_pkg::SER_START_ONES
		&& !start_byte[0];
	assign rd_val = st_r.p2.rs ? st_r.tx_data : st_r.tx_instr;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.p1 = pin_now;
		st_nxt.p2 = st_r.p1;
		st_nxt.p3 = st_r.p2;

		// internal power-up delay, then external pin in parallel modes
		if (st_r.por_cnt != CW'(POR_CYCLES)) begin
			st_nxt.por_cnt = st_r.por_cnt + 1'b1;
		end
		st_nxt.rst_act = (st_r.por_cnt != CW'(POR_CYCLES)) | ext_req;

		// software side: write-one-to-clear first, hardware sets win below
		if (apb_wr && PADDR == vfd_host_pkg::REG_STATUS) begin
			st_nxt.rx_valid = st_r.rx_valid & !PWDATA[vfd_host_pkg::ST_RX_VALID];
			st_nxt.rd_done = st_r.rd_done & !PWDATA[vfd_host_pkg::ST_RD_DONE];
		end
		if (apb_wr && PADDR == vfd_host_pkg::REG_TX_INSTR) begin
			st_nxt.tx_instr = PWDATA[7:0];
		end
		if (apb_wr && PADDR == vfd_host_pkg::REG_TX_DATA) begin
			st_nxt.tx_data = PWDATA[7:0];
		end

		// parallel writes
		if (wr_ev) begin
			if (st_r.p2.wide) begin
				st_nxt.rx_data = st_r.p2.data;
				st_nxt.rx_rs = st_r.p2.rs;
				st_nxt.rx_valid = 1'b1;
			end else if (st_r.hi_next) begin
				st_nxt.hold_nib = st_r.p2.data[7:4];
				st_nxt.hi_next = 1'b0;
			end else begin
				st_nxt.rx_data = {st_r.hold_nib, st_r.p2.data[7:4]};
				st_nxt.rx_rs = st_r.p2.rs;
				st_nxt.rx_valid = 1'b1;
				st_nxt.hi_next = 1'b1;
			end
		end

		// parallel reads
		if (rd_start) begin
			st_nxt.bus_oe = 1'b1;
			if (st_r.p2.wide) begin
				st_nxt.bus_out = rd_val;
			end else if (st_r.hi_next) begin
				st_nxt.bus_out = {rd_val[7:4], 4'h0};
			end else begin
				st_nxt.bus_out = {rd_val[3:0], 4'h0};
			end
		end else if (rd_end) begin
			st_nxt.bus_oe = 1'b0;
			if (st_r.p2.wide || !st_r.hi_next) begin
				st_nxt.rd_done = 1'b1;
			end
			if (!st_r.p2.wide) begin
				st_nxt.hi_next = !st_r.hi_next;
			end
		end

		// serial frame
		if (fs_fall) begin
			st_nxt.s_act = 1'b1;
			st_nxt.s_bad = 1'b0;
			st_nxt.bcnt = 5'h00;
			st_nxt.ocnt = 4'h0;
			st_nxt.ser_oe = 1'b0;
		end else if (st_r.s_act) begin
			if (sck_rise && !st_r.s_bad && st_r.bcnt < vfd_host_pkg::SER_FRAME_BITS) begin
				st_nxt.sh = start_byte;
				st_nxt.bcnt = st_r.bcnt + 5'h01;
				if (st_r.bcnt == vfd_host_pkg::SER_START_BITS - 5'h01) begin
					st_nxt.s_bad = !start_ok;
					st_nxt.s_rw = start_byte[vfd_host_pkg::SER_RW_POS];
					st_nxt.s_rs = start_byte[vfd_host_pkg::SER_RS_POS];
					st_nxt.out_sh = start_byte[vfd_host_pkg::SER_RS_POS] ? st_r.tx_data
						: st_r.tx_instr;
				end
			end
			if (sck_fall && st_r.s_rw && !st_r.s_bad && st_r.bcnt >= vfd_host_pkg::SER_START_BITS
				&& st_r.ocnt < vfd_host_pkg::SER_PAYLOAD_BITS) begin
				st_nxt.ser_out = st_r.out_sh[7];
				st_nxt.out_sh = {st_r.out_sh[6:0], 1'b0};
				st_nxt.ocnt = st_r.ocnt + 4'h1;
				st_nxt.ser_oe = 1'b1;
			end
			if (fs_rise) begin
				st_nxt.s_act = 1'b0;
				st_nxt.ser_oe = 1'b0;
				if (st_r.bcnt == vfd_host_pkg::SER_FRAME_BITS && !st_r.s_bad) begin
					if (st_r.s_rw) begin
						st_nxt.rd_done = 1'b1;
					end else begin
						st_nxt.rx_data = st_r.sh;
						st_nxt.rx_rs = st_r.s_rs;
						st_nxt.rx_valid = 1'b1;
					end
				end
			end
		end

		// drivers follow the jumpers; reset clears link state
		if (!par) begin
			st_nxt.bus_oe = 1'b0;
		end
		if (!ser) begin
			st_nxt.ser_oe = 1'b0;
			st_nxt.s_act = 1'b0;
		end
		if (st_r.rst_act) begin
			st_nxt.hi_next = 1'b1;
			st_nxt.bus_oe = 1'b0;
			st_nxt.ser_oe = 1'b0;
			st_nxt.s_act = 1'b0;
		end

		// apb answer: data and pready registered together, one cycle after the first access cycle
		st_nxt.pready = PSEL & PENABLE & !st_r.pready;
		st_nxt.prdata = 32'h0000_0000;
		st_nxt.pslverr = 1'b0;
		if (PSEL && PENABLE && !st_r.pready) begin
			case (PADDR)
				vfd_host_pkg::REG_RX_VALUE: begin
					st_nxt.prdata[7:0] = st_r.rx_data;
					st_nxt.prdata[vfd_host_pkg::RX_RS_POS] = st_r.rx_rs;
				end
				vfd_host_pkg::REG_STATUS: begin
					st_nxt.prdata[vfd_host_pkg::ST_RX_VALID] = st_r.rx_valid;
					st_nxt.prdata[vfd_host_pkg::ST_RD_DONE] = st_r.rd_done;
					st_nxt.prdata[vfd_host_pkg::ST_MODE_LO +: 2] = st_r.p2.mode;
					st_nxt.prdata[vfd_host_pkg::ST_WIDE] = st_r.p2.wide;
					st_nxt.prdata[vfd_host_pkg::ST_RESET] = st_r.rst_act;
					st_nxt.prdata[vfd_host_pkg::ST_HI_NEXT] = st_r.hi_next;
				end
				vfd_host_pkg::REG_TX_INSTR: begin
					st_nxt.prdata[7:0] = st_r.tx_instr;
				end
				vfd_host_pkg::REG_TX_DATA: begin
					st_nxt.prdata[7:0] = st_r.tx_data;
				end
				default: begin
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end else begin
			st_nxt.prdata = st_r.prdata;
			st_nxt.pslverr = st_r.pslverr;
		end
	end

	always_ff @(posedge CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= '0;
			st_r.p1 <= '1;
			st_r.p2 <= '1;
			st_r.p3 <= '1;
			st_r.rst_act <= 1'b1;
			st_r.hi_next <= 1'b1;
			st_r.tx_instr <= vfd_host_pkg::TX_INSTR_RESET;
			st_r.tx_data <= vfd_host_pkg::TX_DATA_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign PRDATA = st_r.prdata;
	assign PREADY = st_r.pready;
	assign PSLVERR = st_r.pslverr;
	assign DATA_BUS_LINES_OUT = st_r.bus_out;
	assign DATA_BUS_LINES_OE = st_r.bus_oe;
	assign SERIAL_OUT = st_r.ser_out;
	assign SERIAL_OE = st_r.ser_oe;
	assign CORE_RESET = st_r.rst_act;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n_r);

	property p_es_write;
		es && wr_ev && st_r.p2.wide |=> st_r.rx_valid && st_r.rx_data == $past(st_r.p2.data);
	endproperty
	a_es_write: assert property (p_es_write) else $error("byte write not captured");

	property p_rs_class;
		wr_ev && st_r.p2.wide |=> st_r.rx_rs == $past(st_r.p2.rs);
	endproperty
	a_rs_class: assert property (p_rs_class) else $error("register select lost");

	property p_es_read;
		es && rd_start |=> DATA_BUS_LINES_OE ##0 DATA_BUS_LINES_OUT == ($past(st_r.p2.wide)
			? $past(rd_val) : {($past(st_r.hi_next) ? $past(rd_val[7:4]) : $past(rd_val[3:0])),
			4'h0});
	endproperty
	a_es_read: assert property (p_es_read) else $error("read data not driven");

	property p_ss_write;
		ss && wr_ev |=> st_r.hi_next != $past(st_r.hi_next) || st_r.rx_valid;
	endproperty
	a_ss_write: assert property (p_ss_write) else $error("strobe write ignored");

	property p_ss_read;
		ss && rd_start |=> DATA_BUS_LINES_OE && DATA_BUS_LINES_OUT[3:0] == ($past(st_r.p2.wide)
			? $past(rd_val[3:0]) : 4'h0);
	endproperty
	a_ss_read: assert property (p_ss_read) else $error("read strobe not answered");

	property p_nibble_low;
		wr_ev && !st_r.p2.wide && !st_r.hi_next
			|=> st_r.rx_data[3:0] == $past(st_r.p2.data[7:4]) && st_r.hi_next;
	endproperty
	a_nibble_low: assert property (p_nibble_low) else $error("lower nibble misplaced");

	property p_nibble_first;
		wr_ev && !st_r.p2.wide && st_r.hi_next |=> !st_r.hi_next;
	endproperty
	a_nibble_first: assert property (p_nibble_first) else $error("nibble order broken");

	property p_ext_reset;
		par && st_r.p2.ext_sel && !st_r.p2.ext_n |=> CORE_RESET;
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("external reset ignored");

	property p_serial_no_ext;
		ser && st_r.por_cnt == CW'(POR_CYCLES) |=> !CORE_RESET;
	endproperty
	a_serial_no_ext: assert property (p_serial_no_ext) else $error("reset in serial mode");

	property p_bad_start;
		st_r.s_bad && !fs_fall |=> !$rose(st_r.rx_valid) && !SERIAL_OE;
	endproperty
	a_bad_start: assert property (p_bad_start) else $error("bad frame acted on");

	property p_ser_read_bit;
		sck_fall && st_r.s_act && st_r.s_rw && !st_r.s_bad && !fs_rise
			&& st_r.bcnt >= vfd_host_pkg::SER_START_BITS && st_r.ocnt < 4'h8
			|=> SERIAL_OE && SERIAL_OUT == $past(st_r.out_sh[7]);
	endproperty
	a_ser_read_bit: assert property (p_ser_read_bit) else $error("serial bit not output");

	c_nibble_write: cover property (wr_ev && !st_r.p2.wide ##[1:200] wr_ev);
	c_ser_write: cover property (fs_rise && st_r.bcnt == 5'h10 && !st_r.s_rw && !st_r.s_bad);
	c_ser_read: cover property (fs_rise && st_r.bcnt == 5'h10 && st_r.s_rw && !st_r.s_bad);
	c_ext_reset: cover property ($rose(ext_req));

endmodule : vfd_host_interface

`default_nettype wire

// ### test/vfd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// host processor on the pin side of the block
// ----
module vfd_host_model (
	// clock
	input  wire logic       clk,
	// parallel pins
	input  wire logic [7:0] bus,
	output logic            en,
	output logic            rw,
	output logic            wr_n,
	output logic            rd_n,
	output logic            rs,
	output logic [7:0]      dout,
	output logic            drv,
	// serial pins
	input  wire logic       si_line,
	output logic            fs_n,
	output logic            sck,
	output logic            si,
	output logic            si_drv
);
	initial begin
		{en, rw, rs, drv, si, si_drv} = '0;
		{wr_n, rd_n, fs_n, sck} = '1;
		dout = '0;
	end

	// one strobe cycle; strobes and data held far beyond the pin timing
	task automatic xfer(input logic sep, rd, r, input logic [7:0] v, output logic [7:0] q);
		@(posedge clk);
		rw <= rd;
		rs <= r;
		drv <= !rd;
		dout <= v;
		if (!sep)
			en <= 1'b1;
		else if (rd)
			rd_n <= 1'b0;
		else
			wr_n <= 1'b0;
		repeat (30) @(posedge clk);
		q = bus;
		{wr_n, rd_n} <= 2'b11;
		en <= 1'b0;
		repeat (30) @(posedge clk);
		drv <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : xfer

	task automatic put(input logic sep, wd, r, input logic [7:0] v);
		logic [7:0] q;
		if (wd) begin
			xfer(sep, 1'b0, r, v, q);
		end else begin
			xfer(sep, 1'b0, r, {v[7:4], ~v[7:4]}, q);
			xfer(sep, 1'b0, r, {v[3:0], ~v[3:0]}, q);
		end
	endtask : put

	task automatic get(input logic sep, wd, r, output logic [7:0] v);
		logic [7:0] a;
		logic [7:0] b;
		xfer(sep, 1'b1, r, 8'h00, a);
		if (!wd)
			xfer(sep, 1'b1, r, 8'h00, b);
		v = wd ? a : {a[7:4], b[7:4]};
	endtask : get

	// serial frame of nb shift clocks; the line is released for read payload
	task automatic ser(input logic [7:0] st, pay, input int nb, output logic [7:0] q);
		logic [15:0] fr;
		fr = {st, pay};
		q = '0;
		@(posedge clk);
		#3 fs_n = 1'b0;
		#200;
		for (int i = 0; i < nb; i++) begin
			if (i == 8)
				#1100;
			sck = 1'b0;
			si_drv = !(st[2] && i >= 8);
			si = fr[15 - i];
			#62.5;
			if (i >= 8)
				q[15 - i] = si_line;
			sck = 1'b1;
			#62.5;
		end
		#600;
		fs_n = 1'b1;
		si_drv = 1'b0;
		#700;
	endtask : ser
endmodule : vfd_host_model

`default_nettype wire

// ### test/vfd_host_interface_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module vfd_host_interface_test;
	localparam int POR = 20;
	localparam logic [7:0] A_RX = vfd_host_pkg::REG_RX_VALUE;
	localparam logic [7:0] A_ST = vfd_host_pkg::REG_STATUS;
	localparam logic [7:0] A_TI = vfd_host_pkg::REG_TX_INSTR;
	localparam logic [7:0] A_TD = vfd_host_pkg::REG_TX_DATA;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
	logic        wide, ext_sel, ext_n, bus_oe, en, rw, wr_n, rd_n, rs, hdrv;
	logic        fs_n, sck, si, si_drv, so, so_oe, core_rst;
	logic [1:0]  mode;
	logic [7:0]  paddr, bus_out, hd, q;
	logic [31:0] pwdata, prdata, r;
	int          n_fail = 0;
	int          comparisons = 0;
	// released lines float to the pull-up level
	wire logic [7:0] bus = bus_oe ? bus_out : (hdrv ? hd : 8'hFF);
	wire logic si_line = so_oe ? so : (si_drv ? si : 1'b1);

	vfd_host_interface #(.POR_CYCLES(POR)) vfd_host_interface_inst (
		.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.MODE_SEL(mode), .WIDE_SEL(wide), .EXT_RESET_SEL(ext_sel), .EXT_RESET_N(ext_n),
		.ENABLE_STROBE(en), .READ_WRITE(rw), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
		.REGISTER_SELECT(rs), .DATA_BUS_LINES_IN(bus), .DATA_BUS_LINES_OUT(bus_out),
		.DATA_BUS_LINES_OE(bus_oe), .FRAME_SELECT_N(fs_n), .SHIFT_CLK(sck),
		.SERIAL_IN(si_line), .SERIAL_OUT(so), .SERIAL_OE(so_oe), .CORE_RESET(core_rst));

	vfd_host_model vfd_host_model_inst (
		.clk(clk), .bus(bus), .en(en), .rw(rw), .wr_n(wr_n), .rd_n(rd_n), .rs(rs),
		.dout(hd), .drv(hdrv), .si_line(si_line), .fs_n(fs_n), .sck(sck), .si(si),
		.si_drv(si_drv));

	always #5 clk = ~clk;

	// ----
	// bus tasks
	// ----
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task automatic results;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 20) begin
			n_fail++;
			results();
		end
	endtask : apb

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, r & m)
	endtask : rdm

	// ----
	// sequence
	// ----
	initial begin
		{clk, rstn, psel, penable, pwrite, ext_sel} = '0;
		{paddr, pwdata} = '0;
		mode = vfd_host_pkg::MODE_ENABLE_STROBE;
		{wide, ext_n} = 2'b11;
		wt(8);
		rstn <= 1'b1;
		wt(10);
		`CHK("core reset", 1'b1, core_rst)
		wt(POR + 10);
		`CHK("core reset", 1'b0, core_rst)
		rdm(A_TI, 32'hFF, 32'h0);
		rdm(A_TD, 32'hFF, 32'h0);
		rdm(A_ST, 32'h3F, 32'h10);
		apb(1'b1, 8'h10, 32'h1);
		`CHK("slave error", 1'b1, e)
		apb(1'b1, A_TI, 32'h3C);
		apb(1'b1, A_TD, 32'hC3);
		rdm(A_TI, 32'hFF, 32'h3C);
		vfd_host_model_inst.put(1'b0, 1'b1, 1'b1, 8'hA5);
		rdm(A_RX, 32'h1FF, 32'h1A5);
		apb(1'b1, A_ST, 32'h1);
		rdm(A_ST, 32'h1, 32'h0);
		vfd_host_model_inst.get(1'b0, 1'b1, 1'b0, q);
		`CHK("bus read", 8'h3C, q)
		vfd_host_model_inst.get(1'b0, 1'b1, 1'b1, q);
		`CHK("bus read", 8'hC3, q)
		rdm(A_ST, 32'h2, 32'h2);
		wide <= 1'b0;
		wt(5);
		vfd_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 8'h96, q);
		rdm(A_ST, 32'h41, 32'h0);
		vfd_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 8'h69, q);
		rdm(A_RX, 32'h1FF, 32'h096);
		rdm(A_ST, 32'h41, 32'h41);
		mode <= vfd_host_pkg::MODE_SEPARATE_STROBE;
		wt(5);
		vfd_host_model_inst.put(1'b1, 1'b0, 1'b1, 8'h5A);
		rdm(A_RX, 32'h1FF, 32'h15A);
		vfd_host_model_inst.get(1'b1, 1'b0, 1'b1, q);
		`CHK("bus read", 8'hC3, q)
		wide <= 1'b1;
		wt(5);
		vfd_host_model_inst.get(1'b1, 1'b1, 1'b0, q);
		`CHK("bus read", 8'h3C, q)
		apb(1'b1, A_ST, 32'h1);
		ext_sel <= 1'b1;
		ext_n <= 1'b0;
		wt(60);
		`CHK("core reset", 1'b1, core_rst)
		rdm(A_ST, 32'h20, 32'h20);
		vfd_host_model_inst.put(1'b1, 1'b1, 1'b0, 8'h11);
		rdm(A_ST, 32'h1, 32'h0);
		ext_n <= 1'b1;
		wt(POR + 10);
		`CHK("core reset", 1'b0, core_rst)
		mode <= vfd_host_pkg::MODE_SERIAL;
		ext_n <= 1'b0;
		wt(20);
		`CHK("core reset", 1'b0, core_rst)
		ext_n <= 1'b1;
		wt(5);
		vfd_host_model_inst.ser(8'hF8, 8'h81, 16, q);
		rdm(A_RX, 32'h1FF, 32'h081);
		vfd_host_model_inst.ser(8'hFA, 8'h7E, 16, q);
		rdm(A_RX, 32'h1FF, 32'h17E);
		vfd_host_model_inst.ser(8'hFC, 8'h00, 16, q);
		`CHK("serial read", 8'h3C, q)
		vfd_host_model_inst.ser(8'hFE, 8'h00, 16, q);
		`CHK("serial read", 8'hC3, q)
		apb(1'b1, A_ST, 32'h1);
		vfd_host_model_inst.ser(8'hF9, 8'h55, 16, q);
		vfd_host_model_inst.ser(8'hFA, 8'h55, 12, q);
		rdm(A_ST, 32'h1, 32'h0);
		vfd_host_model_inst.ser(8'hFA, 8'h42, 16, q);
		rdm(A_RX, 32'h1FF, 32'h142);
		results();
	end

	initial begin
		#900000;
		n_fail++;
		results();
	end
endmodule : vfd_host_interface_test

`default_nettype wire
